// File: hw/fdc_pkg.sv
// Summary of operation
// R1: Identify command returns the fixed identification byte.
// R2: Loopback takes 256 bytes and returns the same bytes in order.
// R3: Loopback never enables a disc write.
// R4: Self-test passing reports result word 0000; anything else is failure.
// R5: Jump-status query returns 2 after any self-test completes.
// R6: Basic self-test, read and write suppressed, touches no disc medium.
// R7: Read-only self-test reads the medium but never writes it.
// R8: Read/write self-test on cylinder 0-75, about seven seconds per cylinder.
// R9: End command enters the polling state watching drive status.
// R10: Polling keeps parallel poll off until a status change, then asserts it.
// R11: Opening the door is a status change seen by polling.
// R12: Status request returns status words and clears pending error flags.
// R13: Status shows drive ready and medium present.
// R14: Status shows medium write protected.
// R15: Device answers only at its host-selected bus address 0-7.
// R16: Host issues clear after each self-test or status-change test.
// R17: Seek positions the drive to cylinder, head and sector as given.
// R18: Buffered reads move data in bursts of 256 bytes.
// R19: Read offers a reduced-margin verify option; write offers none.
// R20: Self-test result is one 16-bit word; jump status one byte.
package fdc_pkg;
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          ST_CYL_S    = 7;
  localparam int          ST_CYL_CYC  = CLK_HZ * ST_CYL_S;
  localparam int          LOOP_LEN    = 256;
  localparam int          BURST_LEN   = 256;
  localparam logic [6:0]  MAX_CYL     = 7'h4b;
  localparam logic [7:0]  JSQ_AFTER   = 8'h02;
  localparam logic [7:0]  JSQ_RESET   = 8'h00;
  localparam logic [15:0] ST_PASS     = 16'h0000;
  localparam logic [15:0] ST_BAD_CYL  = 16'h0001;
  localparam logic [15:0] ST_BAD_DRV  = 16'h0002;
  localparam logic [15:0] ST_BAD_WP   = 16'h0004;
  localparam int          DRV_RDY     = 0;
  localparam int          DRV_MEDIA   = 1;
  localparam int          DRV_WPROT   = 2;
  localparam int          DRV_DOOR    = 3;
  localparam int          ERR_ST      = 0;
  localparam int          ERR_CHG     = 1;
  localparam int          FIFO_W      = 8;
  localparam int          FIFO_D      = 32;

  typedef enum logic [3:0] {
    OP_IDENT = 4'h0, OP_LOOPW = 4'h1, OP_LOOPR = 4'h2, OP_SELF  = 4'h3,
    OP_JSQ   = 4'h4, OP_STAT  = 4'h5, OP_END   = 4'h6, OP_CLEAR = 4'h7,
    OP_SEEK  = 4'h8, OP_READ  = 4'h9, OP_WRITE = 4'ha
  } fdc_op_t;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_EMIT = 9'h002, S_LIN  = 9'h004,
    S_LOUT = 9'h008, S_SELF = 9'h010, S_POLL = 9'h020,
    S_SEEK = 9'h040, S_READ = 9'h080, S_WRIT = 9'h100
  } fdc_state_t;
endpackage : fdc_pkg

// File: hw/fdc_responder.sv
`timescale 1ns/1ps
`default_nettype none

module fdc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  // Fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // Drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   n;
  } fdc_fifo_st_t;
  fdc_fifo_st_t s, next_s;
  logic [W-1:0] mem [D];
  logic         wr, rd;

  assign o_in_ready  = s.n != (AW+1)'(D);
  assign o_out_valid = s.n != '0;
  assign o_out_data  = mem[s.rp];
  assign wr = i_in_valid & o_in_ready;
  assign rd = o_out_valid & i_out_ready;

  always_comb begin
    next_s = s;
    if (wr) next_s.wp = s.wp + 1'b1;
    if (rd) next_s.rp = s.rp + 1'b1;
    if (wr & ~rd) next_s.n = s.n + 1'b1;
    else if (rd & ~wr) next_s.n = s.n - 1'b1;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) s <= '0;
    else s <= next_s;
  end

  always_ff @(posedge i_mclk) begin
    if (wr) mem[s.wp] <= i_in_data;
  end
endmodule : fdc_fifo

module fdc_responder #(
  parameter int         P_ST_CYL_CYC = fdc_pkg::ST_CYL_CYC,
  parameter logic [7:0] P_ID_CODE    = 8'h5a  // Arbitrary value
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  // Command
  input  wire logic [2:0]       i_dev_addr,
  input  wire logic             i_cmd_valid,
  output logic                  o_cmd_ready,
  input  wire logic [2:0]       i_cmd_addr,
  input  wire fdc_pkg::fdc_op_t i_cmd_op,
  input  wire logic [6:0]       i_cmd_cyl,
  input  wire logic             i_cmd_head,
  input  wire logic [4:0]       i_cmd_sec,
  input  wire logic [15:0]      i_cmd_cnt,
  input  wire logic             i_cmd_wr_incl,
  input  wire logic             i_cmd_rd_incl,
  input  wire logic             i_cmd_buffered,
  input  wire logic             i_cmd_verify,
  // Host data in
  input  wire logic             i_din_valid,
  output logic                  o_din_ready,
  input  wire logic [7:0]       i_din_data,
  // Host data out
  output logic                  o_dout_valid,
  input  wire logic             i_dout_ready,
  output logic [7:0]            o_dout_data,
  output logic                  o_burst_start,
  output logic                  o_ppoll,
  // Drive pins
  input  wire logic             i_drv_ready,
  input  wire logic             i_drv_media,
  input  wire logic             i_drv_wprot,
  input  wire logic             i_drv_door_open,
  // Drive mechanics and data
  output logic                  o_seek_req,
  output logic [6:0]            o_seek_cyl,
  output logic                  o_seek_head,
  output logic [4:0]            o_seek_sec,
  input  wire logic             i_seek_done,
  output logic                  o_disc_rd_en,
  output logic                  o_disc_wr_en,
  output logic                  o_disc_margin,
  input  wire logic             i_disc_valid,
  output logic                  o_disc_rready,
  input  wire logic [7:0]       i_disc_data,
  output logic                  o_disc_wvalid,
  input  wire logic             i_disc_wready,
  output logic [7:0]            o_disc_wdata
);
  import fdc_pkg::*;

  typedef struct packed {
    fdc_state_t st;
    logic       op_wr, op_rd, op_buf, op_ver;
    logic [16:0] rem;
    logic [8:0]  idx;
    logic [31:0] obuf;
    logic [2:0]  on;
    logic [7:0]  jsq;
    logic [1:0]  err;
    logic        ppoll, seek_req, burst, wv;
    logic [7:0]  wdata;
    logic [6:0]  cyl;
    logic        head;
    logic [4:0]  sec;
    logic [27:0] timer;
    logic [3:0]  sy1, sy2, last;
    logic [2:0]  arm;
  } fdc_st_t;
  fdc_st_t s, next_s;

  logic [7:0]  lmem [LOOP_LEN];
  logic        taken, chg, push_v, push_r, din_hs, rd_hs;
  logic [7:0]  push_d;
  logic [15:0] st_res, w1, w2;
  logic [16:0] len;

  assign o_cmd_ready = (s.st == S_IDLE) | (s.st == S_POLL);
  assign taken = i_cmd_valid & o_cmd_ready & (i_cmd_addr == i_dev_addr);  // [R15]
  assign chg = s.arm[2] & ((s.sy2 ^ s.last) != 4'h0);  // [R11]
  assign len = (i_cmd_cnt == 16'h0000) ? 17'(BURST_LEN) : {1'b0, i_cmd_cnt};
  assign w1 = {14'h0000, s.err};
  assign w2 = {13'h0000, s.sy2[DRV_WPROT], ~s.sy2[DRV_MEDIA],
               ~s.sy2[DRV_RDY]};  // [R13] [R14]

  always_comb begin
    st_res = ST_PASS;  // [R4]
    if (i_cmd_rd_incl && !(s.sy2[DRV_RDY] && s.sy2[DRV_MEDIA])) st_res = ST_BAD_DRV;
    else if (i_cmd_rd_incl && i_cmd_wr_incl && i_cmd_cyl > MAX_CYL) st_res = ST_BAD_CYL;
    else if (i_cmd_rd_incl && i_cmd_wr_incl && s.sy2[DRV_WPROT]) st_res = ST_BAD_WP;
  end

  always_comb begin
    push_v = 1'b0;
    push_d = s.obuf[31:24];
    case (s.st)
      S_EMIT: push_v = s.on != 3'h0;
      S_LOUT: begin
        push_v = 1'b1;
        push_d = lmem[s.idx[7:0]];  // [R2]
      end
      S_READ: begin
        push_v = i_disc_valid & (s.rem != 17'h0);
        push_d = i_disc_data;
      end
      default: push_v = 1'b0;
    endcase
  end

  assign o_din_ready = (s.st == S_LIN) |
                       ((s.st == S_WRIT) & (s.rem != 17'h0) & (~s.wv | i_disc_wready));
  assign din_hs = i_din_valid & o_din_ready;
  assign o_disc_rready = (s.st == S_READ) & push_r & (s.rem != 17'h0);
  assign rd_hs = o_disc_rready & i_disc_valid;

  fdc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .i_mclk      (i_mclk),
    .i_rstn      (i_rstn),
    .i_in_valid  (push_v),
    .o_in_ready  (push_r),
    .i_in_data   (push_d),
    .o_out_valid (o_dout_valid),
    .i_out_ready (i_dout_ready),
    .o_out_data  (o_dout_data)
  );

  always_comb begin
    next_s = s;
    next_s.sy1 = {i_drv_door_open, i_drv_wprot, i_drv_media, i_drv_ready};
    next_s.sy2 = s.sy1;
    next_s.last = s.sy2;
    next_s.arm = {s.arm[1:0], 1'b1};
    next_s.seek_req = 1'b0;
    next_s.burst = 1'b0;
    case (s.st)
      S_IDLE: begin
        if (taken) begin
          case (i_cmd_op)
            OP_IDENT: begin
              next_s.obuf = {P_ID_CODE, 24'h000000};  // [R1]
              next_s.on = 3'h1;
              next_s.st = S_EMIT;
            end
            OP_LOOPW: begin
              next_s.idx = 9'h000;
              next_s.st = S_LIN;
            end
            OP_LOOPR: begin
              next_s.idx = 9'h000;
              next_s.st = S_LOUT;
            end
            OP_SELF: begin
              next_s.op_rd = i_cmd_rd_incl;
              next_s.op_wr = i_cmd_wr_incl & i_cmd_rd_incl;  // [R6]
              next_s.cyl = i_cmd_cyl;
              next_s.obuf = {st_res, 16'h0000};  // [R20]
              next_s.on = 3'h2;
              next_s.timer = i_cmd_rd_incl ? 28'(P_ST_CYL_CYC) : 28'h0000001;  // [R8]
              next_s.st = S_SELF;
            end
            OP_JSQ: begin
              next_s.obuf = {s.jsq, 24'h000000};  // [R20]
              next_s.on = 3'h1;
              next_s.st = S_EMIT;
            end
            OP_STAT: begin
              next_s.obuf = {w1, w2};
              next_s.on = 3'h4;
              next_s.err = 2'b00;  // [R12]
              next_s.st = S_EMIT;
            end
            OP_END: begin
              next_s.ppoll = 1'b0;
              next_s.st = S_POLL;  // [R9]
            end
            OP_CLEAR: begin
              next_s.jsq = JSQ_RESET;
              next_s.err = 2'b00;
              next_s.ppoll = 1'b0;
            end
            OP_SEEK: begin
              next_s.cyl = i_cmd_cyl;  // [R17]
              next_s.head = i_cmd_head;
              next_s.sec = i_cmd_sec;
              next_s.seek_req = 1'b1;
              next_s.st = S_SEEK;
            end
            OP_READ: begin
              next_s.rem = len;
              next_s.idx = 9'h000;
              next_s.op_buf = i_cmd_buffered;
              next_s.op_ver = i_cmd_verify;  // [R19]
              next_s.st = S_READ;
            end
            OP_WRITE: begin
              next_s.rem = len;
              next_s.st = S_WRIT;
            end
            default: next_s.st = S_IDLE;
          endcase
        end
      end
      S_EMIT: begin
        if (push_r && s.on != 3'h0) begin
          next_s.obuf = {s.obuf[23:0], 8'h00};
          next_s.on = s.on - 3'h1;
          if (s.on == 3'h1) next_s.st = S_IDLE;
        end
      end
      S_LIN: begin
        if (din_hs) begin
          next_s.idx = s.idx + 9'h001;
          if (s.idx == 9'(LOOP_LEN - 1)) next_s.st = S_IDLE;  // [R2]
        end
      end
      S_LOUT: begin
        if (push_r) begin
          next_s.idx = s.idx + 9'h001;
          if (s.idx == 9'(LOOP_LEN - 1)) next_s.st = S_IDLE;
        end
      end
      S_SELF: begin
        next_s.timer = s.timer - 28'h0000001;
        if (s.timer == 28'h0000001) begin
          next_s.jsq = JSQ_AFTER;  // [R5]
          next_s.st = S_EMIT;
          if (s.obuf[31:16] != ST_PASS) next_s.err[ERR_ST] = 1'b1;
        end
      end
      S_POLL: begin
        if (chg) next_s.ppoll = 1'b1;  // [R10]
        if (taken && i_cmd_op == OP_CLEAR) begin
          next_s.ppoll = 1'b0;
          next_s.err = 2'b00;
          next_s.jsq = JSQ_RESET;
          next_s.st = S_IDLE;
        end
      end
      S_SEEK: if (i_seek_done) next_s.st = S_IDLE;
      S_READ: begin
        if (rd_hs) begin
          next_s.rem = s.rem - 17'h00001;
          next_s.idx = {1'b0, s.idx[7:0] + 8'h01};
          next_s.burst = s.op_buf & (s.idx[7:0] == 8'h00);  // [R18]
        end
        if (s.rem == 17'h0) next_s.st = S_IDLE;
      end
      S_WRIT: begin
        if (s.wv && i_disc_wready) next_s.wv = 1'b0;
        if (din_hs) begin
          next_s.wv = 1'b1;
          next_s.wdata = i_din_data;
          next_s.rem = s.rem - 17'h00001;
        end
        if (s.rem == 17'h0 && !s.wv) next_s.st = S_IDLE;
      end
      default: next_s.st = S_IDLE;
    endcase
    if (chg) next_s.err[ERR_CHG] = 1'b1;  // [R12]
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
      s.st <= S_IDLE;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (s.st == S_LIN && din_hs) lmem[s.idx[7:0]] <= i_din_data;
  end

  assign o_ppoll = s.ppoll;
  assign o_burst_start = s.burst;
  assign o_seek_req = s.seek_req;
  assign o_seek_cyl = s.cyl;
  assign o_seek_head = s.head;
  assign o_seek_sec = s.sec;
  assign o_disc_wvalid = s.wv;
  assign o_disc_wdata = s.wdata;
  assign o_disc_rd_en = (s.st == S_READ) | ((s.st == S_SELF) & s.op_rd);  // [R7]
  assign o_disc_wr_en = (s.st == S_WRIT) | ((s.st == S_SELF) & s.op_wr);  // [R3]
  assign o_disc_margin = (s.st == S_READ) & s.op_ver;  // [R19]

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence s_end_cmd;
    taken && i_cmd_op == OP_END;
  endsequence
  sequence s_poll_idle;
    s.st == S_POLL && !o_ppoll;
  endsequence

  AST_IDENT: assert property (taken && i_cmd_op == OP_IDENT && s.st == S_IDLE  // [R1]
    |=> s.st == S_EMIT && s.obuf[31:24] == P_ID_CODE && s.on == 3'h1)
    else $error("identify byte not loaded");
  AST_LOOP_NO_WR: assert property ((s.st == S_LIN || s.st == S_LOUT)  // [R3]
    |-> !o_disc_wr_en && !o_disc_rd_en)
    else $error("disc enabled during loopback");
  AST_ST_PASS: assert property (taken && i_cmd_op == OP_SELF && !i_cmd_rd_incl  // [R4]
    && s.st == S_IDLE |=> s.obuf[31:16] == ST_PASS ##1 s.st == S_EMIT)
    else $error("basic self-test not reporting zero");
  AST_JSQ: assert property (s.st == S_SELF && s.timer == 28'h0000001  // [R5]
    |=> s.jsq == JSQ_AFTER && s.st == S_EMIT)
    else $error("jump status not 2 after self-test");
  AST_BASIC: assert property (s.st == S_SELF && !s.op_rd  // [R6]
    |-> !o_disc_rd_en && !o_disc_wr_en)
    else $error("basic self-test touched disc");
  AST_RO: assert property (s.st == S_SELF && s.op_rd && !s.op_wr |-> !o_disc_wr_en)  // [R7]
    else $error("read-only self-test wrote disc");
  AST_END: assert property (s.st == S_IDLE ##0 s_end_cmd |=> s_poll_idle)  // [R9]
    else $error("end did not enter polling");
  AST_PPOLL: assert property (s_poll_idle ##0 chg && !(taken && i_cmd_op == OP_CLEAR)  // [R10]
    |=> o_ppoll ##1 (o_ppoll || s.st == S_IDLE))
    else $error("parallel poll not raised on change");
  AST_STAT: assert property (taken && i_cmd_op == OP_STAT && s.st == S_IDLE && !chg  // [R12]
    |=> s.err == 2'b00 && s.on == 3'h4)
    else $error("status did not clear errors");
  AST_ADDR: assert property (i_cmd_valid && i_cmd_addr != i_dev_addr && s.st == S_IDLE  // [R15]
    |=> s.st == S_IDLE && !o_seek_req)
    else $error("command taken at foreign address");
  AST_SEEK: assert property (taken && i_cmd_op == OP_SEEK && s.st == S_IDLE  // [R17]
    |=> o_seek_req && o_seek_cyl == $past(i_cmd_cyl) ##1 !o_seek_req)
    else $error("seek request not a single pulse");
endmodule : fdc_responder

`default_nettype wire

// File: sim/fdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_host_model (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  // Bytes from the device
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  output logic            o_ready
);
  logic [1:0] ph;
  logic [7:0] rxq[$];
  // Stalls one cycle in four, takes bytes at the edge
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      if (i_valid === 1'b1 && o_ready) rxq.push_back(i_data);
    end
  end
  assign o_ready = (ph != 2'h3);
endmodule : fdc_host_model
`default_nettype wire

// File: sim/test_flexible_disc_bus_command_responder.sv
`timescale 1ns/1ps
`default_nettype none
module test_flexible_disc_bus_command_responder;
  import fdc_pkg::*;
  localparam logic [7:0] ID = 8'h3c;  // Arbitrary value
  localparam logic [2:0] DA = 3'h6;
  logic       mclk, rstn, cmd_valid, cmd_ready, head, wr_incl, rd_incl, buffered, verify;
  logic [2:0] dev_addr, cmd_addr;
  fdc_op_t    cmd_op;
  logic [6:0] cyl, seek_cyl;
  logic [4:0] sec, seek_sec;
  logic [15:0] cnt, w;
  logic       din_valid, din_ready, dout_valid, dout_ready, burst, ppoll;
  logic [7:0] din_data, dout_data, disc_data, disc_wdata, b;
  logic       drv_rdy, drv_media, drv_wp, drv_door, seek_req, seek_head, seek_done;
  logic       rd_en, wr_en, margin, disc_valid, disc_rready, disc_wvalid, wr_seen, marg_seen;
  logic [7:0] wq[$];
  int         fail_count, checks_done, bursts;

  fdc_responder #(.P_ST_CYL_CYC(20), .P_ID_CODE(ID)) dut_u (
    .i_mclk(mclk), .i_rstn(rstn), .i_dev_addr(dev_addr), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(cmd_ready), .i_cmd_addr(cmd_addr), .i_cmd_op(cmd_op), .i_cmd_cyl(cyl),
    .i_cmd_head(head), .i_cmd_sec(sec), .i_cmd_cnt(cnt), .i_cmd_wr_incl(wr_incl),
    .i_cmd_rd_incl(rd_incl), .i_cmd_buffered(buffered), .i_cmd_verify(verify),
    .i_din_valid(din_valid), .o_din_ready(din_ready), .i_din_data(din_data),
    .o_dout_valid(dout_valid), .i_dout_ready(dout_ready), .o_dout_data(dout_data),
    .o_burst_start(burst), .o_ppoll(ppoll), .i_drv_ready(drv_rdy), .i_drv_media(drv_media),
    .i_drv_wprot(drv_wp), .i_drv_door_open(drv_door), .o_seek_req(seek_req),
    .o_seek_cyl(seek_cyl), .o_seek_head(seek_head), .o_seek_sec(seek_sec),
    .i_seek_done(seek_done), .o_disc_rd_en(rd_en), .o_disc_wr_en(wr_en),
    .o_disc_margin(margin), .i_disc_valid(disc_valid), .o_disc_rready(disc_rready),
    .i_disc_data(disc_data), .o_disc_wvalid(disc_wvalid), .i_disc_wready(1'b1),
    .o_disc_wdata(disc_wdata));
  fdc_host_model host_u (.i_mclk(mclk), .i_rstn(rstn), .i_valid(dout_valid),
    .i_data(dout_data), .o_ready(dout_ready));

  always #25 mclk = ~mclk;
  // Disc byte source and event watchers
  always @(posedge mclk) begin
    if (disc_valid && disc_rready === 1'b1) disc_data <= #1 disc_data + 8'h01;
    if (burst === 1'b1) bursts++;
    if (wr_en === 1'b1) wr_seen = 1'b1;
    if ((rd_en === 1'b1 || wr_en === 1'b1) && margin === 1'b1) marg_seen = 1'b1;
    if (disc_wvalid === 1'b1) wq.push_back(disc_wdata);
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tmo(input string nm);
    fail_count++;
    $display("CHECK FAILED %s expected done seen timeout", nm);
    final_report();
  endtask : tmo
  task automatic cmd(input fdc_op_t op, input logic [2:0] a);
    int k;
    k = 0;
    @(posedge mclk);
    #1;
    cmd_op = op;
    cmd_addr = a;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin
      if (++k > 5000) tmo("cmd_ready");
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
  endtask : cmd
  task automatic pop();
    int k;
    k = 0;
    while (host_u.rxq.size() == 0) begin
      if (++k > 5000) tmo("host_bytes");
      @(posedge mclk);
      #1;
    end
    b = host_u.rxq.pop_front();
  endtask : pop
  task automatic getw();
    pop();
    w[15:8] = b;
    pop();
    w[7:0] = b;
  endtask : getw
  task automatic t_ident();
    cmd(OP_IDENT, DA);
    pop();
    chk("ident", {8'h00, ID}, {8'h00, b});
    cmd(OP_IDENT, DA ^ 3'h1);
    repeat (10) @(posedge mclk);
    chk("wrong_addr_bytes", 16'h0000, 16'(host_u.rxq.size()));
    $display("test ident done");
  endtask : t_ident
  task automatic t_loop();
    int k;
    wr_seen = 1'b0;
    cmd(OP_LOOPW, DA);
    din_valid = 1'b1;
    for (int i = 0; i < LOOP_LEN; i++) begin
      din_data = 8'(i) ^ {8{i[0]}};
      k = 0;
      while (din_ready !== 1'b1) begin
        if (++k > 100) tmo("din_ready");
        @(posedge mclk);
        #1;
      end
      @(posedge mclk);
      #1;
    end
    din_valid = 1'b0;
    cmd(OP_LOOPR, DA);
    for (int i = 0; i < LOOP_LEN; i++) begin
      pop();
      chk("loop_byte", {8'h00, 8'(i) ^ {8{i[0]}}}, {8'h00, b});
    end
    chk("loop_disc_wr", 16'h0000, {15'h0000, wr_seen});
    $display("test loopback done");
  endtask : t_loop
  task automatic t_self();
    logic [24:0] tab[4] = '{{2'b01, 7'h00, ST_PASS}, {2'b10, 7'h05, ST_PASS},
                            {2'b11, MAX_CYL, ST_PASS}, {2'b11, 7'h4c, ST_BAD_CYL}};
    for (int i = 0; i < 4; i++) begin
      {rd_incl, wr_incl, cyl} = tab[i][24:16];
      wr_seen = 1'b0;
      cmd(OP_SELF, DA);
      getw();
      chk("self_result", tab[i][15:0], w);
      chk("self_disc_wr", {15'h0000, tab[i][24] & tab[i][23]}, {15'h0000, wr_seen});
      cmd(OP_JSQ, DA);
      pop();
      chk("jump_status", {8'h00, JSQ_AFTER}, {8'h00, b});
      cmd(OP_CLEAR, DA);
      cmd(OP_JSQ, DA);
      pop();
      chk("jump_status_clr", {8'h00, JSQ_RESET}, {8'h00, b});
    end
    $display("test selftest done");
  endtask : t_self
  task automatic t_stat();
    logic [2:0] pins[3] = '{3'b111, 3'b000, 3'b011};
    for (int i = 0; i < 3; i++) begin
      {drv_wp, drv_media, drv_rdy} = pins[i];
      repeat (6) @(posedge mclk);
      cmd(OP_STAT, DA);
      getw();
      chk("stat_w1_set", 16'h0002, w);
      getw();
      cmd(OP_STAT, DA);
      getw();
      chk("stat_w1_clr", 16'h0000, w);
      getw();
      chk("stat_w2", {13'h0000, drv_wp, ~drv_media, ~drv_rdy}, w);
    end
    $display("test status done");
  endtask : t_stat
  task automatic t_poll();
    int k;
    cmd(OP_END, DA);
    repeat (6) @(posedge mclk);
    chk("ppoll_idle", 16'h0000, {15'h0000, ppoll});
    #1 drv_door = 1'b1;
    k = 0;
    while (ppoll !== 1'b1 && k < 10) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk("ppoll_door", 16'h0001, {15'h0000, ppoll});
    cmd(OP_CLEAR, DA);
    #1 chk("ppoll_clr", 16'h0000, {15'h0000, ppoll});
    drv_door = 1'b0;
    $display("test poll done");
  endtask : t_poll
  task automatic t_seek();
    int k;
    {cyl, head, sec} = {7'h2a, 1'b1, 5'h11};
    cmd(OP_SEEK, DA);
    k = 0;
    while (seek_req !== 1'b1) begin
      if (++k > 20) tmo("seek_req");
      @(posedge mclk);
      #1;
    end
    chk("seek_loc", {3'h0, 7'h2a, 1'b1, 5'h11}, {3'h0, seek_cyl, seek_head, seek_sec});
    seek_done = 1'b1;
    @(posedge mclk);
    #1 seek_done = 1'b0;
    $display("test seek done");
  endtask : t_seek
  task automatic t_read();
    {cnt, buffered, verify, disc_data, bursts, marg_seen} = {16'd300, 2'b11, 8'h00, 32'd0, 1'b0};
    cmd(OP_READ, DA);
    for (int i = 0; i < 300; i++) begin
      pop();
      chk("read_byte", {8'h00, 8'(i)}, {8'h00, b});
    end
    chk("read_bursts", 16'd2, 16'(bursts));
    chk("read_margin", 16'h0001, {15'h0000, marg_seen});
    $display("test read done");
  endtask : t_read
  task automatic t_write();
    int k;
    {cnt, verify, marg_seen} = {16'd4, 2'b10};
    cmd(OP_WRITE, DA);
    din_valid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      din_data = 8'h30 + 8'(i);
      k = 0;
      while (din_ready !== 1'b1) begin
        if (++k > 100) tmo("din_ready");
        @(posedge mclk);
        #1;
      end
      @(posedge mclk);
      #1;
    end
    din_valid = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("write_count", 16'd4, 16'(wq.size()));
    for (int i = 0; i < 4 && wq.size() > 0; i++) begin
      chk("write_byte", {8'h00, 8'h30 + 8'(i)}, {8'h00, wq.pop_front()});
    end
    chk("write_margin", 16'h0000, {15'h0000, marg_seen});
    $display("test write done");
  endtask : t_write

  initial begin
    {mclk, rstn, cmd_valid, head, wr_incl, rd_incl, buffered, verify} = 8'h00;
    {dev_addr, cmd_addr, cyl, sec, cnt} = {DA, DA, 7'h00, 5'h00, 16'h0000};
    cmd_op = OP_CLEAR;
    {din_valid, din_data, disc_data, seek_done, disc_valid} = {1'b0, 16'h0000, 2'b01};
    {drv_rdy, drv_media, drv_wp, drv_door} = 4'b1100;
    {fail_count, checks_done, bursts, wr_seen, marg_seen} = {96'd0, 2'b00};
    repeat (8) @(posedge mclk);
    #1 rstn = 1'b1;
    cmd(OP_CLEAR, DA);
    t_ident();
    t_loop();
    t_self();
    t_stat();
    t_poll();
    t_seek();
    t_read();
    t_write();
    final_report();
  end
endmodule : test_flexible_disc_bus_command_responder
`default_nettype wire
